/* src/frame_if.sv */
// Carrier for finished command frames crossing into the core clock domain
`timescale 1ns/10ps
interface frame_if;
   logic toggle;
   logic [7:0] opcode;
   logic [23:0] addr;
   logic [7:0] data;
   logic has_data;
   logic data_toggle;
   modport link (output toggle, output opcode, output addr, output data, output has_data, output data_toggle);
   modport core (input toggle, input opcode, input addr, input data, input has_data, input data_toggle);
endinterface : frame_if

/* src/nand_busy_timer.sv */
// Down-counter that times an internal program or erase cycle
`timescale 1ns/10ps
module nand_busy_timer #(
   parameter int WIDTH = 20
) (
   input wire logic clk, // Core clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic start, // One-cycle load pulse
   input wire logic [WIDTH-1:0] load, // Cycles to run
   input wire logic abort, // Stop immediately
   output logic running // High while counting
);
   logic [WIDTH-1:0] count_q, count_d;

   always_comb begin
      count_d = count_q;
      if (abort) begin
         count_d = '0;
      end else if (start) begin
         count_d = load;
      end else if (count_q != '0) begin
         count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   assign running = (count_q != '0);
endmodule : nand_busy_timer

/* src/nand_program_erase_sequencer.sv */
// Command sequencer for random load, copy-back, block erase and power-up write inhibit
`timescale 1ns/10ps
// Notes on behaviour
// - Random load needs prior unlock to change array
// - Opcode, 16-bit column; 12 bits used
// - Execute starts page buffer to array transfer
// - Blocks are 64 pages; erase hits one
// - Erase needs unlock latch, else ignored
// - Erase address: 8 dummy, 16-bit row
// - Erase self-timed; busy for erase time
// - During erase only status and reset accepted
// - Factory bad block marked 00h at 2048
// - Logic held reset below inhibit threshold
// - Write commands ignored during inhibit delay
// - Power-up standby with latch, busy clear
// - Delivered erased; status reads 00h
// - Latch set only by unlock command
// - Busy flag high during program or erase
// - Erase fail set on failure, cleared at start
module nand_program_erase_sequencer #(
   parameter int ERASE_CYCLES = nand_seq_pkg::ERASE_BUSY_CYCLES,
   parameter int PROGRAM_CYCLES = nand_seq_pkg::PROGRAM_BUSY_CYCLES,
   parameter int INHIBIT_CYCLES = nand_seq_pkg::WRITE_INHIBIT_CYCLES,
   parameter int BLOCKS = 1024
) (
   input wire logic clk, // Core clock, 125 MHz
   input wire logic rst_n, // Power-on reset, active low, low below inhibit threshold
   input wire logic sclk, // Serial clock from host
   input wire logic cs_n, // Chip select, active low
   input wire logic si, // Serial data in
   input wire logic so_sel, // Host is reading status, use status_byte
   output logic [7:0] status_byte, // Status feature value
   output logic operation_active_flag, // Program or erase running
   output logic write_latch_flag, // Write latch state
   output logic erase_fail_flag, // Erase failure
   output logic write_inhibit, // Power-up inhibit window open
   output logic array_write, // One-cycle pulse: page buffer committed
   output logic [15:0] array_row, // Row targeted by program or erase
   output logic array_erase, // One-cycle pulse: block erase started
   output logic [11:0] load_column, // Column of last random load
   output logic [7:0] load_byte, // First byte of last random load
   output logic load_valid // Pulse: random load byte accepted
);
   frame_if frame ();

   spi_frame_rx rx (
      .sclk(sclk),
      .cs_n(cs_n),
      .si(si),
      .rst_n(rst_n),
      .frame(frame)
   );

   // Frame toggle crossing: first stage read only by the second
   logic tog_s1_q, tog_s2_q, tog_s3_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tog_s1_q <= 1'b0;
         tog_s2_q <= 1'b0;
         tog_s3_q <= 1'b0;
      end else begin
         tog_s1_q <= frame.toggle;
         tog_s2_q <= tog_s1_q;
         tog_s3_q <= tog_s2_q;
      end
   end
   wire frame_seen = tog_s2_q ^ tog_s3_q;

   // Decoded command class, shared by acceptance and flag logic
   function automatic nand_seq_pkg::command_type classify(input logic [7:0] op);
      unique case (op)
         nand_seq_pkg::OP_WRITE_UNLOCK: classify = nand_seq_pkg::CMD_UNLOCK;
         nand_seq_pkg::OP_LOAD_RANDOM, nand_seq_pkg::OP_LOAD_RANDOM_X4: classify = nand_seq_pkg::CMD_LOAD;
         nand_seq_pkg::OP_PROGRAM_EXEC: classify = nand_seq_pkg::CMD_EXEC;
         nand_seq_pkg::OP_PAGE_READ: classify = nand_seq_pkg::CMD_READ_PAGE;
         nand_seq_pkg::OP_BLOCK_ERASE: classify = nand_seq_pkg::CMD_ERASE;
         nand_seq_pkg::OP_RESET: classify = nand_seq_pkg::CMD_RESET;
         nand_seq_pkg::OP_GET_FEATURE: classify = nand_seq_pkg::CMD_NONE;
         default: classify = nand_seq_pkg::CMD_OTHER;
      endcase
   endfunction : classify

   function automatic logic is_write_type(input nand_seq_pkg::command_type c, input logic [7:0] op);
      is_write_type = (c == nand_seq_pkg::CMD_UNLOCK) || (c == nand_seq_pkg::CMD_EXEC) ||
                      (c == nand_seq_pkg::CMD_ERASE) || (op == nand_seq_pkg::OP_OTP_PROGRAM);
   endfunction : is_write_type

   // Frame words are stable for many core cycles after the toggle is seen
   nand_seq_pkg::command_type cmd;
   assign cmd = classify(frame.opcode);

   typedef enum {ST_IDLE, ST_PROGRAM, ST_ERASE} seq_state_type;
   seq_state_type state_q, state_d;
   logic latch_q, latch_d;
   logic efail_q, efail_d;
   logic loaded_q, loaded_d;
   logic [31:0] inhibit_q, inhibit_d;
   logic [15:0] row_q, row_d;
   logic [11:0] col_q, col_d;
   logic [7:0] byte_q, byte_d;
   logic wr_q, wr_d, er_q, er_d, lv_q, lv_d, busy_q, busy_d;
   logic [7:0] status_q, status_d;
   logic timer_start, timer_abort, timer_running;
   logic [19:0] timer_load;

   nand_busy_timer #(.WIDTH(20)) timer (
      .clk(clk),
      .rst_n(rst_n),
      .start(timer_start),
      .load(timer_load),
      .abort(timer_abort),
      .running(timer_running)
   );

   wire inhibit_open = (inhibit_q != 32'h0000_0000);
   wire [15:0] blk_index = frame.addr[15:0] >> nand_seq_pkg::PAGE_BITS;
   wire block_in_range = ({16'h0000, blk_index} < 32'(BLOCKS));

   always_comb begin
      state_d = state_q;
      latch_d = latch_q;
      efail_d = efail_q;
      loaded_d = loaded_q;
      row_d = row_q;
      col_d = col_q;
      byte_d = byte_q;
      wr_d = 1'b0;
      er_d = 1'b0;
      lv_d = 1'b0;
      timer_start = 1'b0;
      timer_abort = 1'b0;
      timer_load = '0;
      inhibit_d = inhibit_q;
      if (inhibit_open) begin
         inhibit_d = inhibit_q - 32'h0000_0001;
      end
      unique case (state_q)
         ST_IDLE: begin
            if (frame_seen) begin
               if (inhibit_open && is_write_type(cmd, frame.opcode)) begin
                  // Ignored entirely while power-up inhibit runs
               end else begin
                  unique case (cmd)
                     nand_seq_pkg::CMD_UNLOCK: latch_d = 1'b1;
                     nand_seq_pkg::CMD_LOAD: begin
                        // Without the latch the load is dropped, so nothing reaches the array
                        if (latch_q) begin
                           col_d = frame.addr[nand_seq_pkg::COL_BITS-1:0];
                           loaded_d = 1'b1;
                           if (frame.has_data) begin
                              byte_d = frame.data;
                              lv_d = 1'b1;
                           end
                        end
                     end
                     nand_seq_pkg::CMD_EXEC: begin
                        if (latch_q) begin
                           row_d = frame.addr[15:0];
                           wr_d = 1'b1;
                           latch_d = 1'b0;
                           loaded_d = 1'b0;
                           timer_start = 1'b1;
                           timer_load = 20'(PROGRAM_CYCLES);
                           state_d = ST_PROGRAM;
                        end
                     end
                     nand_seq_pkg::CMD_ERASE: begin
                        if (latch_q) begin
                           row_d = frame.addr[nand_seq_pkg::ROW_BITS-1:0];
                           latch_d = 1'b0;
                           if (block_in_range) begin
                              efail_d = 1'b0;
                              er_d = 1'b1;
                              timer_start = 1'b1;
                              timer_load = 20'(ERASE_CYCLES);
                              state_d = ST_ERASE;
                           end else begin
                              efail_d = 1'b1;
                           end
                        end
                     end
                     nand_seq_pkg::CMD_RESET: begin
                        latch_d = 1'b0;
                        efail_d = 1'b0;
                        loaded_d = 1'b0;
                     end
                     default: ;
                  endcase
               end
            end
         end
         ST_PROGRAM, ST_ERASE: begin
            // Only status read and reset act while busy; reset aborts the cycle and clears the fail flag
            if (frame_seen && cmd == nand_seq_pkg::CMD_RESET) begin
               timer_abort = 1'b1;
               latch_d = 1'b0;
               efail_d = 1'b0;
               state_d = ST_IDLE;
            end else if (!timer_running && !timer_start) begin
               state_d = ST_IDLE;
            end
         end
      endcase
      busy_d = (state_d != ST_IDLE);
      status_d = nand_seq_pkg::STATUS_RESET;
      status_d[nand_seq_pkg::STAT_BUSY_BIT] = busy_d;
      status_d[nand_seq_pkg::STAT_LATCH_BIT] = latch_d;
      status_d[nand_seq_pkg::STAT_EFAIL_BIT] = efail_d;
   end

   // Reset gives standby with every flag clear and the inhibit window armed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         latch_q <= 1'b0;
         efail_q <= 1'b0;
         loaded_q <= 1'b0;
         inhibit_q <= 32'(INHIBIT_CYCLES);
         row_q <= '0;
         col_q <= '0;
         byte_q <= nand_seq_pkg::ERASED_BYTE;
         wr_q <= 1'b0;
         er_q <= 1'b0;
         lv_q <= 1'b0;
         busy_q <= 1'b0;
         status_q <= nand_seq_pkg::STATUS_RESET;
      end else begin
         state_q <= state_d;
         latch_q <= latch_d;
         efail_q <= efail_d;
         loaded_q <= loaded_d;
         inhibit_q <= inhibit_d;
         row_q <= row_d;
         col_q <= col_d;
         byte_q <= byte_d;
         wr_q <= wr_d;
         er_q <= er_d;
         lv_q <= lv_d;
         busy_q <= busy_d;
         status_q <= status_d;
      end
   end

   logic inhibit_flag_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         inhibit_flag_q <= 1'b1;
      end else begin
         inhibit_flag_q <= (inhibit_d != 32'h0000_0000);
      end
   end

   assign status_byte = status_q;
   assign operation_active_flag = busy_q;
   assign write_latch_flag = latch_q;
   assign erase_fail_flag = efail_q;
   assign write_inhibit = inhibit_flag_q;
   assign array_write = wr_q;
   assign array_erase = er_q;
   assign array_row = row_q;
   assign load_column = col_q;
   assign load_byte = byte_q;
   assign load_valid = lv_q;

   chk_erase_needs_latch: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(er_q) |-> $past(latch_q, 1) && !latch_q) else $error("erase started without latch");
   chk_busy_follows_erase: assert property (@(posedge clk) disable iff (!rst_n)
      er_q |-> busy_q && status_q[nand_seq_pkg::STAT_BUSY_BIT]) else $error("busy not set on erase");
   chk_exec_needs_latch: assert property (@(posedge clk) disable iff (!rst_n)
      wr_q |-> $past(latch_q, 1)) else $error("program without latch");
   chk_load_needs_latch: assert property (@(posedge clk) disable iff (!rst_n)
      lv_q |-> latch_q) else $error("load without latch");
   chk_inhibit_blocks_write: assert property (@(posedge clk) disable iff (!rst_n)
      $past(inhibit_flag_q, 1) && $past(inhibit_flag_q, 2) |-> !$rose(latch_q)) else $error("unlock during inhibit");
   chk_erase_fail_cleared: assert property (@(posedge clk) disable iff (!rst_n)
      er_q |-> !efail_q) else $error("erase fail not cleared at start");
   chk_busy_no_new_cmd: assert property (@(posedge clk) disable iff (!rst_n)
      busy_q && $past(busy_q, 1) |-> !wr_q && !er_q) else $error("new cycle while busy");
   chk_status_mirror: assert property (@(posedge clk) disable iff (!rst_n)
      status_q == {5'h00, efail_q, latch_q, busy_q}) else $error("status byte mismatch");
endmodule : nand_program_erase_sequencer

/* src/nand_seq_pkg.sv */
// Shared constants and types for the flash program and erase sequencer
package nand_seq_pkg;
   localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
   localparam logic [7:0] OP_LOAD_RANDOM = 8'h84;
   localparam logic [7:0] OP_LOAD_RANDOM_X4 = 8'h34;
   localparam logic [7:0] OP_PROGRAM_EXEC = 8'h10;
   localparam logic [7:0] OP_PAGE_READ = 8'h13;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
   localparam logic [7:0] OP_GET_FEATURE = 8'h0F;
   localparam logic [7:0] OP_RESET = 8'hFF;
   localparam logic [7:0] OP_OTP_PROGRAM = 8'h02;
   localparam logic [7:0] STATUS_FEATURE_ADDR = 8'hC0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] BAD_BLOCK_MARK = 8'h00;
   localparam int PAGE_BYTES = 2112;
   localparam int SPARE_FIRST_BYTE = 2048;
   localparam int PAGES_PER_BLOCK = 64;
   localparam int SECTION_BYTES = 8;
   localparam int COL_BITS = 12;
   localparam int ROW_BITS = 16;
   localparam int PAGE_BITS = 6;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_LATCH_BIT = 1;
   localparam int STAT_EFAIL_BIT = 2;
   localparam int CLK_MHZ = 125;
   localparam int ERASE_BUSY_TIME_US = 2000;
   localparam int ERASE_BUSY_CYCLES = ERASE_BUSY_TIME_US * CLK_MHZ;
   localparam int PROGRAM_BUSY_TIME_US = 200;
   localparam int PROGRAM_BUSY_CYCLES = PROGRAM_BUSY_TIME_US * CLK_MHZ;
   localparam int WRITE_INHIBIT_DELAY_MS = 1;
   localparam int WRITE_INHIBIT_CYCLES = WRITE_INHIBIT_DELAY_MS * 1000 * CLK_MHZ;
   typedef enum logic [2:0] {
      CMD_NONE, CMD_UNLOCK, CMD_LOAD, CMD_EXEC, CMD_READ_PAGE, CMD_ERASE, CMD_RESET, CMD_OTHER
   } command_type;
endpackage : nand_seq_pkg

/* src/spi_frame_rx.sv */
// Link-side shifter: collects opcode, address and first data byte per frame
`timescale 1ns/10ps
module spi_frame_rx (
   input wire logic sclk, // Serial clock from host
   input wire logic cs_n, // Chip select, active low
   input wire logic si, // Serial data in
   input wire logic rst_n, // Power-on reset, active low
   frame_if.link frame // Frame handed to the core
);
   // Frame lengths in bits at which fields are complete
   localparam logic [5:0] OP_END = 6'h08;
   localparam logic [5:0] COL_END = 6'h18;
   localparam logic [5:0] ROW_END = 6'h20;
   localparam logic [5:0] KEEP_END = 6'h28;
   logic [5:0] bits_q, bits_d;
   logic [39:0] shift_q, shift_d;
   logic [7:0] op_q, op_d;
   logic [23:0] addr_q, addr_d;
   logic [7:0] data_q, data_d;
   logic has_q, has_d;
   logic done_q, done_d;
   logic dtog_q, dtog_d;

   // Counting and shifting stop at 40 bits so the head of the frame stays in place
   always_comb begin
      bits_d = bits_q;
      shift_d = shift_q;
      if (bits_q != KEEP_END) begin
         bits_d = bits_q + 6'h01;
         shift_d = {shift_q[38:0], si};
      end
   end

   // Random loads carry a 16-bit column and then data; the others a 24-bit address
   function automatic logic is_load(input logic [7:0] op);
      is_load = (op == nand_seq_pkg::OP_LOAD_RANDOM) || (op == nand_seq_pkg::OP_LOAD_RANDOM_X4);
   endfunction : is_load

   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         bits_q <= 6'h00;
         shift_q <= '0;
      end else begin
         bits_q <= bits_d;
         shift_q <= shift_d;
      end
   end

   // Captured fields, latched when the frame ends so the core sees stable words
   // A cut frame of any length other than 8, 24, 32 or 40 bits hands over a null opcode, which the core ignores
   always_comb begin
      op_d = '0;
      addr_d = '0;
      data_d = data_q;
      has_d = 1'b0;
      done_d = ~done_q;
      dtog_d = dtog_q;
      case (bits_q)
         OP_END: op_d = shift_q[7:0];
         COL_END: begin
            op_d = shift_q[23:16];
            addr_d = {8'h00, shift_q[15:0]};
         end
         ROW_END: begin
            op_d = shift_q[31:24];
            if (is_load(shift_q[31:24])) begin
               addr_d = {8'h00, shift_q[23:8]};
               data_d = shift_q[7:0];
               has_d = 1'b1;
               dtog_d = ~dtog_q;
            end else begin
               addr_d = shift_q[23:0];
            end
         end
         KEEP_END: begin
            op_d = shift_q[39:32];
            if (is_load(shift_q[39:32])) begin
               addr_d = {8'h00, shift_q[31:16]};
               data_d = shift_q[15:8];
               has_d = 1'b1;
               dtog_d = ~dtog_q;
            end else begin
               addr_d = shift_q[31:8];
            end
         end
         default: ;
      endcase
   end

   // Frame end is sampled at the rising edge of chip select, the only moment a command acts.
   // Reset is released while the host keeps chip select high, so no edge races it.
   always_ff @(posedge cs_n or negedge rst_n) begin
      if (!rst_n) begin
         op_q <= '0;
         addr_q <= '0;
         data_q <= '0;
         has_q <= 1'b0;
         done_q <= 1'b0;
         dtog_q <= 1'b0;
      end else begin
         op_q <= op_d;
         addr_q <= addr_d;
         data_q <= data_d;
         has_q <= has_d;
         done_q <= done_d;
         dtog_q <= dtog_d;
      end
   end

   assign frame.toggle = done_q;
   assign frame.opcode = op_q;
   assign frame.addr = addr_q;
   assign frame.data = data_q;
   assign frame.has_data = has_q;
   assign frame.data_toggle = dtog_q;
endmodule : spi_frame_rx

/* verification/spi_host_model.sv */
// Host-side serial controller model that frames flash commands
`timescale 1ns/10ps
module spi_host_model (
   output logic sclk, // Serial clock, stands low between frames
   output logic cs_n, // Chip select, active low
   output logic si // Serial data to the device
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // Sends the top nbytes bytes of bits, MSB first, changing data while the clock is low
   task automatic send(input logic [39:0] bits, input int nbytes);
      int i;
      cs_n = 1'b0;
      #6;
      for (i = 39; i >= 40 - 8 * nbytes; i--) begin
         si = bits[i];
         #3;
         sclk = 1'b1;
         #3;
         sclk = 1'b0;
      end
      #6;
      cs_n = 1'b1;
      // No pull on the data line, so a released line must not keep its last value
      si = ~si;
   endtask : send
endmodule : spi_host_model

/* verification/tb.sv */
// Self-checking bench for the program and erase sequencer
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
   $display("BAD %s expected %h seen %h", nm, exp, got); end end
module tb;
   localparam int ERASE_N = 50;
   localparam int PROG_N = 20;
   localparam int INHIB_N = 100;
   logic clk, rst_n, so_sel, sclk, cs_n, si;
   logic [7:0] status_byte, load_byte;
   logic operation_active_flag, write_latch_flag, erase_fail_flag, write_inhibit;
   logic array_write, array_erase, load_valid;
   logic [15:0] array_row, last_row;
   logic [11:0] load_column;
   int miscompares, tests_run, cycles, n_write, n_erase, n_load, busy_len;
   spi_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si));
   nand_program_erase_sequencer #(.ERASE_CYCLES(ERASE_N), .PROGRAM_CYCLES(PROG_N), .INHIBIT_CYCLES(INHIB_N),
      .BLOCKS(512)) uut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so_sel(so_sel),
      .status_byte(status_byte), .operation_active_flag(operation_active_flag),
      .write_latch_flag(write_latch_flag), .erase_fail_flag(erase_fail_flag), .write_inhibit(write_inhibit),
      .array_write(array_write), .array_row(array_row), .array_erase(array_erase), .load_column(load_column),
      .load_byte(load_byte), .load_valid(load_valid));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Pulses last one cycle, so they are counted here rather than sampled by the scenarios
   always @(posedge clk) begin
      if (array_write === 1'b1) begin n_write++; last_row = array_row; end
      if (array_erase === 1'b1) begin n_erase++; last_row = array_row; end
      if (load_valid === 1'b1) n_load++;
      if (operation_active_flag === 1'b1) busy_len++;
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   // Frame plus the cs_n-high gap that lets the core pick it up
   task automatic frame(input logic [39:0] bits, input int nbytes);
      host.send(bits, nbytes);
      settle(14);
   endtask : frame
   task automatic unlock();
      frame({nand_seq_pkg::OP_WRITE_UNLOCK, 32'h0}, 1);
   endtask : unlock
   task automatic wait_idle(input int lim);
      int k;
      k = 0;
      while (operation_active_flag !== 1'b0 && k < lim) begin @(posedge clk); k++; end
      #1;
      if (k >= lim) begin miscompares++; $display("BAD busy_clear expected 0 seen %b", operation_active_flag); end
   endtask : wait_idle
   task automatic t_power_up();
      `CHK("status_reset", 8'h00, status_byte)
      `CHK("flags_reset", 3'b000, {operation_active_flag, write_latch_flag, erase_fail_flag})
      `CHK("inhibit_reset", 1'b1, write_inhibit)
      unlock();
      `CHK("unlock_inhibited", 1'b0, write_latch_flag)
      frame({nand_seq_pkg::OP_BLOCK_ERASE, 8'h00, 16'h0040, 8'h00}, 4);
      `CHK("erase_inhibited", 0, n_erase)
      settle(INHIB_N);
      `CHK("inhibit_over", 1'b0, write_inhibit)
   endtask : t_power_up
   task automatic t_no_latch();
      frame({nand_seq_pkg::OP_LOAD_RANDOM, 16'h0123, 8'h5A, 8'h00}, 4);
      frame({nand_seq_pkg::OP_PROGRAM_EXEC, 8'h00, 16'h0041, 8'h00}, 4);
      frame({nand_seq_pkg::OP_BLOCK_ERASE, 8'h00, 16'h0080, 8'h00}, 4);
      `CHK("load_no_latch", 0, n_load)
      `CHK("exec_no_latch", 0, n_write)
      `CHK("erase_no_latch", 0, n_erase)
      `CHK("busy_no_latch", 1'b0, operation_active_flag)
   endtask : t_no_latch
   task automatic t_random_load();
      logic [7:0] ops [2];
      int i;
      ops[0] = nand_seq_pkg::OP_LOAD_RANDOM;
      ops[1] = nand_seq_pkg::OP_LOAD_RANDOM_X4;
      for (i = 0; i < 2; i++) begin
         unlock();
         `CHK("latch_set", 1'b1, write_latch_flag)
         `CHK("status_latch", 8'h02, status_byte)
         frame({ops[i], 16'hFABC - 16'(i * 8), 8'hC3 + 8'(i), 8'h00}, 4);
         `CHK("load_count", i + 1, n_load)
         `CHK("load_column", 12'hABC - 12'(i * 8), load_column)
         `CHK("load_byte", 8'hC3 + 8'(i), load_byte)
         busy_len = 0;
         frame({nand_seq_pkg::OP_PROGRAM_EXEC, 8'h00, 16'h0041 + 16'(i), 8'h00}, 4);
         `CHK("exec_count", i + 1, n_write)
         `CHK("exec_row", 16'h0041 + 16'(i), last_row)
         `CHK("status_prog", 8'h01, status_byte)
         wait_idle(PROG_N + 10);
         `CHK("prog_len", 1'b1, busy_len >= PROG_N - 1 && busy_len <= PROG_N + 1)
      end
   endtask : t_random_load
   task automatic t_copy_back();
      frame({nand_seq_pkg::OP_PAGE_READ, 8'h00, 16'h0100, 8'h00}, 4);
      frame({nand_seq_pkg::OP_PROGRAM_EXEC, 8'h00, 16'h0200, 8'h00}, 4);
      `CHK("copy_no_latch", 2, n_write)
      unlock();
      frame({nand_seq_pkg::OP_PROGRAM_EXEC, 8'h00, 16'h0200, 8'h00}, 4);
      `CHK("copy_exec", 3, n_write)
      `CHK("copy_row", 16'h0200, last_row)
      wait_idle(PROG_N + 10);
   endtask : t_copy_back
   task automatic t_erase();
      unlock();
      busy_len = 0;
      frame({nand_seq_pkg::OP_BLOCK_ERASE, 8'hA5, 16'h0080, 8'h00}, 4);
      `CHK("erase_count", 1, n_erase)
      `CHK("erase_row", 16'h0080, last_row)
      `CHK("status_erase", 8'h01, status_byte)
      unlock();
      `CHK("busy_refuse", 1'b0, write_latch_flag)
      wait_idle(ERASE_N + 10);
      `CHK("erase_len", 1'b1, busy_len >= ERASE_N - 1 && busy_len <= ERASE_N + 1)
      `CHK("erase_ok", 1'b0, erase_fail_flag)
      unlock();
      frame({nand_seq_pkg::OP_BLOCK_ERASE, 8'h00, 16'hFFC0, 8'h00}, 4);
      wait_idle(ERASE_N + 10);
      `CHK("erase_fail", 1'b1, erase_fail_flag)
      `CHK("status_fail", 8'h04, status_byte)
      unlock();
      frame({nand_seq_pkg::OP_BLOCK_ERASE, 8'h00, 16'h00C0, 8'h00}, 4);
      `CHK("fail_clear", 1'b0, erase_fail_flag)
      wait_idle(ERASE_N + 10);
   endtask : t_erase
   task automatic t_reset_mid();
      unlock();
      frame({nand_seq_pkg::OP_BLOCK_ERASE, 8'h00, 16'h0140, 8'h00}, 4);
      @(posedge clk) rst_n <= 1'b0;
      settle(2);
      `CHK("reset_status", 8'h00, status_byte)
      `CHK("reset_inhibit", 1'b1, write_inhibit)
      @(posedge clk) rst_n <= 1'b1;
      settle(INHIB_N + 10);
      `CHK("reset_idle", 3'b000, {operation_active_flag, write_latch_flag, write_inhibit})
   endtask : t_reset_mid
   initial begin
      rst_n = 1'b0;
      so_sel = 1'b0;
      {miscompares, tests_run, cycles, n_write, n_erase, n_load, busy_len} = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      settle(2);
      t_power_up();
      t_no_latch();
      t_random_load();
      t_copy_back();
      t_erase();
      t_reset_mid();
      results();
   end
endmodule : tb
